//--- design/upc_uncore_perf_counters.sv
// Uncore performance monitor: agent and scheduler counters, fixed clocktick counter, global control
`timescale 1ns/10ps
module upc_uncore_perf_counters #(
	parameter int NUM_AGENTS = 4,
	parameter int NUM_EVT    = 16
) (
	input  wire logic                              clk,            // Uncore clock, 250 MHz
	input  wire logic                              nrst,           // Sync reset, active low
	input  wire logic [7:0]                        regAddr,        // Register index
	input  wire logic                              regWr,          // Write strobe
	input  wire logic                              regRd,          // Read strobe
	input  wire logic [63:0]                       regWdata,       // Write data
	output logic      [63:0]                       regRdata,       // Read data
	output logic                                   regRvalid,      // Read data valid
	input  wire logic [7:0]                        evtSub [NUM_AGENTS+1][NUM_EVT], // Sub-event bits
	input  wire logic [upc_pkg::RAW_WIDTH-1:0]     occValue [NUM_AGENTS],          // Agent occupancy
	input  wire logic [upc_pkg::NUM_CORES-1:0]     coreIntAck,     // Core serviced interrupt
	output logic      [upc_pkg::NUM_CORES-1:0]     coreWakeReq,    // Wake request pulses
	output logic      [upc_pkg::NUM_CORES-1:0]     corePerfIntReq  // Interrupt request pulses
);

	localparam int NUM_UNITS = NUM_AGENTS + 1;
	localparam int NUM_CTR   = 2 * NUM_UNITS;
	localparam int GPW       = upc_pkg::GP_WIDTH;
	localparam int FXW       = upc_pkg::FIXED_WIDTH;
	localparam int RW        = upc_pkg::RAW_WIDTH;

	upc_pkg::upc_evtsel_type          evtsel_q [NUM_CTR];
	upc_pkg::upc_gctl_type            gctl_q;
	logic [NUM_AGENTS-1:0]            agentEn_q;
	upc_pkg::upc_dec_type             dec;
	logic [GPW-1:0]                   ctrVal   [NUM_CTR];
	logic [NUM_CTR-1:0]               ctrOvf;
	logic [NUM_CTR-1:0]               ctrWr;
	logic [NUM_CTR-1:0]               ctrEn;
	logic [NUM_CTR-1:0]               fwdOvf;
	logic [RW-1:0]                    rawSel   [NUM_CTR];
	logic [FXW-1:0]                   fixedVal;
	logic                             fixedOvf;
	logic                             anyOvf;
	logic [upc_pkg::NUM_CORES-1:0]    pendingVec;
	logic [63:0]                      rdData;

	upc_pkg::upc_evtsel_type          fixedCfg;

	// Index decode shared by the write and read paths
	function automatic upc_pkg::upc_dec_type decodeAddr(input logic [7:0] a);
		upc_pkg::upc_dec_type d;
		d.unitHit = (a[7:4] != 4'h0) && ({28'h000_0000, a[7:4]} <= NUM_UNITS);
		d.unit    = a[7:4] - 4'h1;
		d.sub     = a[3:0];
		return d;
	endfunction : decodeAddr

	function automatic logic [3:0] popCount(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'b000, v[i]};
		end
		return n;
	endfunction : popCount

	assign dec = decodeAddr(regAddr);

	// Fixed counter sees one event every cycle with no filtering
	always_comb begin
		fixedCfg             = '0;
		fixedCfg.localEnable = 1'b1;
	end

	upc_counter #(
		.WIDTH (FXW)
	) u_fixed (
		.clk      (clk),
		.nrst     (nrst),
		.rawCount ({{(RW-1){1'b0}}, 1'b1}),
		.cfg      (fixedCfg),
		.countEn  (gctl_q.globalEnable),
		.wrEn     (regWr && regAddr == upc_pkg::FIXED_CTR_IDX),
		.wrData   (regWdata[FXW-1:0]),
		.count    (fixedVal),
		.ovf      (fixedOvf)
	);

	generate
		for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
			localparam int UNIT = c / 2;
			localparam int SLOT = c % 2;
			localparam logic [3:0] UNIT_IDX = 4'(UNIT);
			localparam logic [3:0] CTR_SUB  = (SLOT == 0) ? upc_pkg::SUB_CTR0 : upc_pkg::SUB_CTR1;
			localparam logic [3:0] SEL_SUB  = (SLOT == 0) ? upc_pkg::SUB_EVTSEL0 : upc_pkg::SUB_EVTSEL1;

			always_comb begin
				rawSel[c] = '0;
				if ({24'h00_0000, evtsel_q[c].eventCode} < NUM_EVT) begin
					rawSel[c] = {2'b00, popCount(evtSub[UNIT][evtsel_q[c].eventCode[$clog2(NUM_EVT)-1:0]]
						& evtsel_q[c].unitQualifierField)};
				end
				if (evtsel_q[c].eventCode == upc_pkg::OCC_EVENT_CODE) begin
					if (SLOT == 0 && UNIT < NUM_AGENTS) begin
						rawSel[c] = occValue[(UNIT < NUM_AGENTS) ? UNIT : 0];
					end else begin
						rawSel[c] = '0;
					end
				end
			end

			if (UNIT < NUM_AGENTS) begin : g_agent
				assign ctrEn[c] = gctl_q.globalEnable & agentEn_q[UNIT] & evtsel_q[c].localEnable;
			end else begin : g_sched
				assign ctrEn[c] = gctl_q.globalEnable & evtsel_q[c].localEnable;
			end

			assign ctrWr[c] = regWr && dec.unitHit && dec.unit == UNIT_IDX && dec.sub == CTR_SUB;

			upc_counter #(
				.WIDTH (GPW)
			) u_ctr (
				.clk      (clk),
				.nrst     (nrst),
				.rawCount (rawSel[c]),
				.cfg      (evtsel_q[c]),
				.countEn  (ctrEn[c]),
				.wrEn     (ctrWr[c]),
				.wrData   (regWdata[GPW-1:0]),
				.count    (ctrVal[c]),
				.ovf      (ctrOvf[c])
			);

			assign fwdOvf[c] = ctrOvf[c] & evtsel_q[c].overflowForward;

			always_ff @(posedge clk) begin
				if (!nrst) begin
					evtsel_q[c] <= upc_pkg::EVTSEL_RESET;
				end else if (regWr && dec.unitHit && dec.unit == UNIT_IDX && dec.sub == SEL_SUB) begin
					evtsel_q[c] <= regWdata[31:0] & upc_pkg::EVTSEL_WMASK;
				end
			end
		end

		for (genvar a = 0; a < NUM_AGENTS; a++) begin : g_box
			localparam logic [3:0] BOX_IDX = 4'(a);
			always_ff @(posedge clk) begin
				if (!nrst) begin
					agentEn_q[a] <= 1'b0;
				end else if (regWr && dec.unitHit && dec.unit == BOX_IDX && dec.sub == upc_pkg::SUB_BOX_CTRL) begin
					agentEn_q[a] <= regWdata[0];
				end
			end
		end
	endgenerate

	// Fixed counter has no forward bit, so its wrap always counts
	assign anyOvf = (|fwdOvf) | fixedOvf;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			gctl_q <= upc_pkg::GCTL_RESET;
		end else begin
			if (regWr && regAddr == upc_pkg::GLOBAL_CTRL_IDX) begin
				gctl_q <= regWdata[31:0] & upc_pkg::GCTL_WMASK;
			end
			if (anyOvf && gctl_q.freezeOnOverflow) begin
				gctl_q.globalEnable <= 1'b0;
			end
		end
	end

	upc_int_router u_router (
		.clk            (clk),
		.nrst           (nrst),
		.trigger        (anyOvf),
		.routeSel       (gctl_q.coreRouteSelect),
		.wakeFirst      (gctl_q.wakeBeforeInterrupt),
		.coreIntAck     (coreIntAck),
		.coreWakeReq    (coreWakeReq),
		.corePerfIntReq (corePerfIntReq),
		.pending        (pendingVec)
	);

	always_comb begin
		rdData = 64'h0000_0000_0000_0000;
		if (regAddr == upc_pkg::GLOBAL_CTRL_IDX) begin
			rdData = {32'h0000_0000, gctl_q};
		end else if (regAddr == upc_pkg::FIXED_CTR_IDX) begin
			rdData = {{(64-FXW){1'b0}}, fixedVal};
		end else if (regAddr == upc_pkg::PENDING_IDX) begin
			rdData = {{(64-upc_pkg::NUM_CORES){1'b0}}, pendingVec};
		end else if (dec.unitHit) begin
			unique case (dec.sub)
				upc_pkg::SUB_EVTSEL0: rdData = {32'h0000_0000, evtsel_q[2*dec.unit]};
				upc_pkg::SUB_EVTSEL1: rdData = {32'h0000_0000, evtsel_q[2*dec.unit+1]};
				upc_pkg::SUB_CTR0:    rdData = {{(64-GPW){1'b0}}, ctrVal[2*dec.unit]};
				upc_pkg::SUB_CTR1:    rdData = {{(64-GPW){1'b0}}, ctrVal[2*dec.unit+1]};
				upc_pkg::SUB_BOX_CTRL: begin
					if ({28'h000_0000, dec.unit} < NUM_AGENTS) begin
						rdData = {63'h0, agentEn_q[dec.unit[$clog2(NUM_AGENTS)-1:0]]};
					end
				end
				default: rdData = 64'h0000_0000_0000_0000;
			endcase
		end
	end

	// Read data registered so the port comes straight from flops
	always_ff @(posedge clk) begin
		if (!nrst) begin
			regRdata  <= 64'h0000_0000_0000_0000;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRd;
			if (regRd) begin
				regRdata <= rdData;
			end
		end
	end

endmodule : upc_uncore_perf_counters

//--- design/upc_pkg.sv
// Shared constants and types for the uncore performance counter block
package upc_pkg;

	localparam int GP_WIDTH    = 44;
	localparam int FIXED_WIDTH = 48;
	localparam int RAW_WIDTH   = 6;
	localparam int NUM_CORES   = 4;

	// Register indices on the software access port
	localparam logic [7:0] GLOBAL_CTRL_IDX = 8'h00;
	localparam logic [7:0] FIXED_CTR_IDX   = 8'h01;
	localparam logic [7:0] PENDING_IDX     = 8'h02;
	// Unit n (agents first, scheduler unit last) sits at (n+1)*16
	localparam logic [3:0] SUB_EVTSEL0     = 4'h0;
	localparam logic [3:0] SUB_EVTSEL1     = 4'h1;
	localparam logic [3:0] SUB_CTR0        = 4'h2;
	localparam logic [3:0] SUB_CTR1        = 4'h3;
	localparam logic [3:0] SUB_BOX_CTRL    = 4'h4;

	// Writable bits; reserved bits stay zero
	localparam logic [31:0] EVTSEL_WMASK   = 32'h1FD4_FFFF;
	localparam logic [31:0] GCTL_WMASK     = 32'hE000_000F;
	localparam logic [31:0] EVTSEL_RESET   = 32'h0000_0000;
	localparam logic [31:0] GCTL_RESET     = 32'h0000_0000;

	// Event code that selects the agent occupancy input
	localparam logic [7:0] OCC_EVENT_CODE  = 8'h80;

	typedef struct packed {
		logic [2:0] rsvd29;
		logic [4:0] thresholdField;
		logic       negateCount;
		logic       localEnable;
		logic       rsvd21;
		logic       overflowForward;
		logic       rsvd19;
		logic       edgeDetect;
		logic [1:0] rsvd16;
		logic [7:0] unitQualifierField;
		logic [7:0] eventCode;
	} upc_evtsel_type;

	typedef struct packed {
		logic       freezeOnOverflow;
		logic       wakeBeforeInterrupt;
		logic       globalEnable;
		logic [24:0] rsvd4;
		logic [3:0] coreRouteSelect;
	} upc_gctl_type;

	typedef struct packed {
		logic       unitHit;
		logic [3:0] unit;
		logic [3:0] sub;
	} upc_dec_type;

endpackage : upc_pkg

//--- design/upc_counter.sv
// One event counter with threshold, negate and edge filtering
`timescale 1ns/10ps
module upc_counter #(
	parameter int WIDTH = upc_pkg::GP_WIDTH
) (
	input  wire logic                             clk,      // Uncore clock
	input  wire logic                             nrst,     // Sync reset, active low
	input  wire logic [upc_pkg::RAW_WIDTH-1:0]    rawCount, // Per-cycle event value
	input  wire upc_pkg::upc_evtsel_type          cfg,      // Event select fields
	input  wire logic                             countEn,  // Combined enables
	input  wire logic                             wrEn,     // Software load strobe
	input  wire logic [WIDTH-1:0]                 wrData,   // Load value
	output logic      [WIDTH-1:0]                 count,    // Counter value
	output logic                                  ovf       // Overflow pulse
);

	logic                 cond;
	logic                 condSense;
	logic                 prev_q;
	logic [WIDTH-1:0]     incr;
	logic [WIDTH:0]       sum;

	always_comb begin
		if (cfg.thresholdField != 5'h00) begin
			cond = rawCount >= {1'b0, cfg.thresholdField};
		end else begin
			cond = rawCount != '0;
		end
		condSense = cond ^ cfg.negateCount;
		if (cfg.edgeDetect) begin
			incr = {{(WIDTH-1){1'b0}}, condSense & ~prev_q};
		end else if (cfg.thresholdField != 5'h00 || cfg.negateCount) begin
			incr = {{(WIDTH-1){1'b0}}, condSense};
		end else begin
			incr = {{(WIDTH-upc_pkg::RAW_WIDTH){1'b0}}, rawCount};
		end
		sum = {1'b0, count} + {1'b0, incr};
	end

	// Edge history tracks the condition every cycle so a re-enable sees no false edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= condSense;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= '0;
		end else if (wrEn) begin
			count <= wrData;
		end else if (countEn) begin
			count <= sum[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ovf <= 1'b0;
		end else begin
			ovf <= countEn & ~wrEn & sum[WIDTH];
		end
	end

endmodule : upc_counter

//--- design/upc_int_router.sv
// Routes overflow interrupts to selected cores, wake request first if asked
`timescale 1ns/10ps
module upc_int_router (
	input  wire logic                          clk,            // Uncore clock
	input  wire logic                          nrst,           // Sync reset, active low
	input  wire logic                          trigger,        // Forwarded overflow
	input  wire logic [upc_pkg::NUM_CORES-1:0] routeSel,       // Selected cores
	input  wire logic                          wakeFirst,      // Wake before interrupt
	input  wire logic [upc_pkg::NUM_CORES-1:0] coreIntAck,     // Core took interrupt
	output logic      [upc_pkg::NUM_CORES-1:0] coreWakeReq,    // Wake pulse per core
	output logic      [upc_pkg::NUM_CORES-1:0] corePerfIntReq, // Interrupt pulse per core
	output logic      [upc_pkg::NUM_CORES-1:0] pending         // Unserviced requests
);

	logic [upc_pkg::NUM_CORES-1:0] wakeStage_q;
	logic [upc_pkg::NUM_CORES-1:0] intNext;

	always_comb begin
		intNext = wakeStage_q;
		if (trigger && !wakeFirst) begin
			intNext = intNext | routeSel;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wakeStage_q    <= '0;
			coreWakeReq    <= '0;
			corePerfIntReq <= '0;
		end else begin
			wakeStage_q    <= (trigger && wakeFirst) ? routeSel : '0;
			coreWakeReq    <= (trigger && wakeFirst) ? routeSel : '0;
			corePerfIntReq <= intNext;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pending <= '0;
		end else begin
			pending <= (pending & ~coreIntAck) | intNext;
		end
	end

endmodule : upc_int_router

//--- verif/upc_core_model.sv
// Behavioural model of the cores that take routed interrupts
`timescale 1ns/10ps
module upc_core_model #(
	parameter int SLOW = 6
) (
	input  wire logic       clk,            // Uncore clock
	input  wire logic       nrst,           // Sync reset, active low
	input  wire logic [3:0] halted,         // Cores asleep at start
	input  wire logic       deliveryEn,     // Debug control delivery enable
	input  wire logic [3:0] coreWakeReq,    // Wake pulses
	input  wire logic [3:0] corePerfIntReq, // Interrupt pulses
	output logic      [3:0] coreIntAck      // Service acks
);
	logic [3:0] awake_q;
	logic [3:0] ack_q;
	int         wait_q [4];

	assign coreIntAck = ack_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			awake_q <= ~halted;
			ack_q <= 4'h0;
			wait_q <= '{default: 0};
		end else begin
			awake_q <= awake_q | coreWakeReq;
			for (int i = 0; i < 4; i++) begin
				ack_q[i] <= (wait_q[i] == 1);
				// Core 2 answers late to stretch pending
				if (corePerfIntReq[i] && deliveryEn && awake_q[i]) begin
					wait_q[i] <= (i == 2) ? SLOW : 1;
				end else if (wait_q[i] != 0) begin
					wait_q[i] <= wait_q[i] - 1;
				end
			end
		end
	end
endmodule : upc_core_model

//--- verif/upc_properties.sv
// Port-level properties of the uncore performance counter block
`timescale 1ns/10ps
module upc_properties #(
	parameter int NUM_AGENTS = 4
) (
	input wire logic        clk,           // Uncore clock
	input wire logic        nrst,          // Sync reset, active low
	input wire logic [7:0]  regAddr,       // Register index
	input wire logic        regWr,         // Write strobe
	input wire logic        regRd,         // Read strobe
	input wire logic [63:0] regWdata,      // Write data
	input wire logic [63:0] regRdata,      // Read data
	input wire logic        regRvalid,     // Read valid
	input wire logic [3:0]  coreWakeReq,   // Wake pulses
	input wire logic [3:0]  corePerfIntReq // Interrupt pulses
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	chk_read_valid_pulse: assert property (regRd |=> regRvalid)
		else $error("read valid missing after read");
	chk_no_stray_valid: assert property (!regRd |=> !regRvalid)
		else $error("read valid without read");
	chk_unmapped_reads_zero: assert property (regRd && regAddr == 8'h0F |=> regRdata == 64'h0)
		else $error("unmapped read not zero");
	chk_rdata_holds: assert property (!regRd |=> $stable(regRdata))
		else $error("read data changed without read");
	chk_ctrl_reserved_zero: assert property (regRd && regAddr == upc_pkg::GLOBAL_CTRL_IDX
		|=> (regRdata & ~{32'h0, upc_pkg::GCTL_WMASK}) == 64'h0)
		else $error("control reserved bits set");
	chk_evtsel_fields_only: assert property (regRd && regAddr[3:1] == 3'h0 && regAddr[7:4] != 4'h0
		&& regAddr[7:4] <= NUM_AGENTS + 1 |=> (regRdata & ~{32'h0, upc_pkg::EVTSEL_WMASK}) == 64'h0)
		else $error("event select reserved bits set");
	chk_route_readback: assert property (regWr && regAddr == 8'h00 ##1 !regWr ##1 regRd && regAddr == 8'h00
		|=> regRdata[3:0] == $past(regWdata[3:0], 3))
		else $error("core route not kept");
	chk_wake_then_int: assert property (coreWakeReq != 4'h0
		|=> (corePerfIntReq & $past(coreWakeReq)) == $past(coreWakeReq))
		else $error("interrupt did not follow wake");

	cover property (coreWakeReq != 4'h0);
	cover property (corePerfIntReq != 4'h0);
	cover property (regRd && regAddr == 8'h0F);
endmodule : upc_properties

//--- verif/upc_uncore_perf_counters_tb.sv
// Self-checking testbench for the uncore performance counter block
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module upc_uncore_perf_counters_tb;
	logic        clk, nrst, regWr, regRd, regRvalid;
	logic [7:0]  regAddr;
	logic [63:0] regWdata, regRdata;
	logic [7:0]  evtSub [5][16];
	logic [5:0]  occValue [4];
	logic [3:0]  coreIntAck, coreWakeReq, corePerfIntReq, wakeSeen;
	logic        wakeClr;
	int          error_cnt, num_checks;

	upc_uncore_perf_counters dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
		.regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .evtSub(evtSub), .occValue(occValue),
		.coreIntAck(coreIntAck), .coreWakeReq(coreWakeReq), .corePerfIntReq(corePerfIntReq));
	upc_core_model cores (.clk(clk), .nrst(nrst), .halted(4'b0110), .deliveryEn(1'b1),
		.coreWakeReq(coreWakeReq), .corePerfIntReq(corePerfIntReq), .coreIntAck(coreIntAck));

	// Cleared through a strobe so the record keeps a single driver
	always @(posedge clk) wakeSeen <= (!nrst || wakeClr) ? 4'h0 : (wakeSeen | coreWakeReq);

	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Strobe is dropped for one idle cycle so tasks can follow each other
	task automatic wr(logic [7:0] a, logic [63:0] d);
		regAddr = a;
		regWdata = d;
		regWr = 1'b1;
		tick();
		regWr = 1'b0;
		tick();
	endtask : wr

	task automatic rd(logic [7:0] a, logic [63:0] e, string nm);
		regAddr = a;
		regRd = 1'b1;
		tick();
		`CHK("regRvalid", 1'b1, regRvalid)
		`CHK(nm, e, regRdata)
		regRd = 1'b0;
		tick();
	endtask : rd

	task automatic wait_int(logic [3:0] e);
		int n;
		n = 0;
		while (corePerfIntReq === 4'h0 && n < 20) begin
			tick();
			n++;
		end
		`CHK("int route", e, corePerfIntReq)
	endtask : wait_int

	task automatic test_regs();
		rd(8'h00, 64'h0, "gctl reset");
		rd(8'h10, 64'h0, "evtsel reset");
		wr(8'h10, '1);
		rd(8'h10, 64'h1FD4_FFFF, "evtsel fields");
		wr(8'h10, 64'h0);
		wr(8'h00, 64'h000A);
		rd(8'h00, 64'h000A, "route bits");
		wr(8'h02, '1);
		rd(8'h02, 64'h0, "pending ro");
		wr(8'h0F, '1);
		rd(8'h0F, 64'h0, "unmapped");
		wr(8'h54, 64'h1);
		rd(8'h54, 64'h0, "sched box ctrl");
	endtask : test_regs

	// Events run 10 cycles inside a 20-cycle global enable window
	task automatic test_counting();
		logic [7:0]  a [13] = '{8'h50, 8'h51, 8'h10, 8'h11, 8'h14, 8'h20, 8'h30, 8'h31, 8'h34, 8'h40, 8'h41,
			8'h44, 8'h01};
		logic [31:0] d [13] = '{32'h0040_0503, 32'h0044_0503, 32'h0340_FF03, 32'h01C0_FF03, 32'h0000_0001,
			32'h0040_FF03, 32'h0040_0080, 32'h0040_0080, 32'h0000_0001, 32'h0000_FF03, 32'h0040_0103,
			32'h0000_0001, 32'h0000_0000};
		foreach (a[i]) wr(a[i], {32'h0, d[i]});
		wr(8'h00, 64'h2000_0000);
		tick(4);
		evtSub[4][3] = 8'h0F;
		evtSub[0][3] = 8'h0F;
		evtSub[1][3] = 8'hFF;
		evtSub[3][3] = 8'h01;
		occValue[2] = 6'h05;
		tick(10);
		evtSub[4][3] = 8'h00;
		evtSub[0][3] = 8'h00;
		evtSub[1][3] = 8'h00;
		evtSub[3][3] = 8'h00;
		occValue[2] = 6'h00;
		tick(4);
		wr(8'h00, 64'h0);
		rd(8'h01, 64'h14, "fixed ticks");
		rd(8'h52, 64'h14, "sched plain");
		rd(8'h53, 64'h1, "sched edge");
		rd(8'h12, 64'hA, "threshold");
		rd(8'h13, 64'hA, "negate");
		rd(8'h22, 64'h0, "agent off");
		rd(8'h32, 64'h32, "occupancy ctr0");
		rd(8'h33, 64'h0, "occupancy ctr1");
		rd(8'h42, 64'h0, "local off");
		rd(8'h43, 64'hA, "agent ctr1");
	endtask : test_counting

	task automatic fire(logic [63:0] ctl);
		wakeClr = 1'b1;
		tick();
		wakeClr = 1'b0;
		wr(8'h50, 64'h0050_0503);
		wr(8'h52, 64'h0FFF_FFFF_FFFF);
		wr(8'h00, ctl);
		evtSub[4][3] = 8'h0F;
		tick();
		evtSub[4][3] = 8'h00;
	endtask : fire

	task automatic test_ovf_wake();
		fire(64'hE000_0005);
		wait_int(4'h5);
		`CHK("wake first", 4'h5, wakeSeen)
		rd(8'h00, 64'hC000_0005, "freeze");
		rd(8'h52, 64'h1, "wrapped");
		tick(10);
		rd(8'h02, 64'h0, "woken served");
	endtask : test_ovf_wake

	task automatic test_ovf_nowake();
		fire(64'h2000_0002);
		wait_int(4'h2);
		`CHK("no wake", 4'h0, wakeSeen)
		tick(10);
		rd(8'h02, 64'h2, "halted unserved");
		rd(8'h00, 64'h2000_0002, "no freeze");
	endtask : test_ovf_nowake

	// Wrap with forwarding off must neither interrupt nor freeze
	task automatic test_ovf_masked();
		wr(8'h50, 64'h0040_0503);
		wr(8'h52, 64'h0FFF_FFFF_FFFF);
		wr(8'h00, 64'hA000_0001);
		evtSub[4][3] = 8'h0F;
		tick();
		evtSub[4][3] = 8'h00;
		wait_int(4'h0);
		rd(8'h00, 64'hA000_0001, "unforwarded no freeze");
		rd(8'h52, 64'h1, "silent wrap");
	endtask : test_ovf_masked

	task automatic finish_test();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		tick(5000);
		error_cnt++;
		finish_test();
	end

	initial begin
		nrst = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 64'h0;
		wakeClr = 1'b0;
		foreach (evtSub[u, e]) evtSub[u][e] = 8'h00;
		foreach (occValue[u]) occValue[u] = 6'h00;
		tick(5);
		nrst = 1'b1;
		tick(2);
		test_regs();
		test_counting();
		test_ovf_wake();
		test_ovf_nowake();
		test_ovf_masked();
		finish_test();
	end
endmodule : upc_uncore_perf_counters_tb

bind upc_uncore_perf_counters upc_properties #(.NUM_AGENTS(NUM_AGENTS)) chk (.clk(clk), .nrst(nrst),
	.regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
	.regRvalid(regRvalid), .coreWakeReq(coreWakeReq), .corePerfIntReq(corePerfIntReq));
